// ---- common/uef_pkg.sv ----
// Purpose: Shared constants and types of the endpoint FIFO block.
// Assumes: Three endpoints, fixed FIFO map.
// Notes:   Base addresses follow capacity times bank count.
`default_nettype none
package uef_pkg;
  localparam int NUM_EP    = 3;
  localparam int EP_W      = 2;
  localparam int BYTE_W    = 8;
  localparam int PTR_W     = 7;
  localparam int CNT_W     = 8;
  localparam int ADDR_W    = 9;
  localparam int MEM_BYTES = 288;
  localparam int BANKS_PP  = 2;
  localparam int EP_CAP   [NUM_EP] = '{32, 64, 64};
  localparam int EP_BANKS [NUM_EP] = '{1, 2, 2};
  localparam int EP_BASE  [NUM_EP] = '{0, 32, 160};
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] PID_OUT      = 2'h0;
  localparam logic [1:0] PID_IN       = 2'h1;
  localparam logic [1:0] PID_SETUP    = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_DROP, ST_TX} uef_state_e;
endpackage : uef_pkg
`default_nettype wire

// ---- common/uef_ep_if.sv ----
// Purpose: Strobes and state between the transaction core and one endpoint.
// Assumes: Strobes are one-cycle pulses, qualified by endpoint except usbRst, which all endpoints share.
// Notes:   One instance per endpoint.
`default_nettype none
interface uef_ep_if;
  import uef_pkg::*;
  logic                 fwRead, fwWrite, clrOut0, clrOut1, setArmed, clrArmed;
  logic                 clrDone, clrSetup, dirWrite, dirValue, fifoRst, usbRst;
  logic                 rxAccept, setup_packet_received, rxBank, rxData1, txAck;
  logic [CNT_W-1:0]     rxCount;
  logic [1:0]           outFlag, armed;
  logic                 setupFlag, doneFlag, dirIn, fwBank, sieBank, toggle;
  logic [PTR_W-1:0]     fwPtr;
  logic [CNT_W-1:0]     byteCnt, inLen;
  modport core (output fwRead, fwWrite, clrOut0, clrOut1, setArmed, clrArmed, clrDone, clrSetup,
                dirWrite, dirValue, fifoRst, usbRst, rxAccept, setup_packet_received, rxBank, rxData1, txAck, rxCount,
                input outFlag, armed, setupFlag, doneFlag, dirIn, fwBank, sieBank, toggle, fwPtr,
                byteCnt, inLen);
  modport ep (input fwRead, fwWrite, clrOut0, clrOut1, setArmed, clrArmed, clrDone, clrSetup,
              dirWrite, dirValue, fifoRst, usbRst, rxAccept, setup_packet_received, rxBank, rxData1, txAck, rxCount,
              output outFlag, armed, setupFlag, doneFlag, dirIn, fwBank, sieBank, toggle, fwPtr,
              byteCnt, inLen);
endinterface : uef_ep_if
`default_nettype wire

// ---- logic/uef_ep_state.sv ----
// Purpose: Status flags, pointer, counters and banks of one endpoint.
// Assumes: Core sends at most one transaction event per cycle.
// Notes:   Hardware set beats a firmware clear in the same cycle.
`default_nettype none
module uef_ep_state #(
  parameter int CAP = 64,
  parameter bit PP  = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  uef_ep_if.ep     bus
);
  import uef_pkg::*;
  logic [1:0]       outFlag, armed;
  logic             setupFlag, doneFlag, dirIn, fwBank, sieBank, toggle;
  logic [PTR_W-1:0] fwPtr;
  logic [CNT_W-1:0] cnt [2];
  logic [CNT_W-1:0] len [2];
  wire  clr     = bus.usbRst | bus.setup_packet_received;
  wire  relOut  = (bus.clrOut0 & outFlag[0]) | (bus.clrOut1 & outFlag[1]);
  wire  relFw   = PP & ((bus.clrOut0 & ~fwBank) | (bus.clrOut1 & fwBank));
  wire  ptrRel  = PP ? relFw : relOut;
  wire  cancel  = bus.clrArmed & |armed;
  wire  ptrMax  = fwPtr == PTR_W'(CAP);
  wire  ptrZero = clr | bus.fifoRst | ptrRel | cancel | bus.clrSetup | (PP & bus.setArmed) | (~PP & bus.txAck);
  wire  [1:0] setOut = {bus.rxAccept & bus.rxBank, bus.rxAccept & ~bus.rxBank};
  wire  [1:0] armSet = {bus.setArmed & fwBank, bus.setArmed & ~fwBank};
  wire  [1:0] ackClr = {bus.txAck & sieBank, bus.txAck & ~sieBank};
  wire  quiet   = ~(bus.rxAccept | bus.setup_packet_received | bus.fifoRst | bus.usbRst);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      outFlag   <= '0;
      armed     <= '0;
      setupFlag <= '0;
      doneFlag  <= '0;
      dirIn     <= '0;
    end else if (clr) begin
      outFlag   <= '0;
      armed     <= '0;
      doneFlag  <= '0;
      dirIn     <= '0;
      setupFlag <= bus.setup_packet_received;
    end else begin
      outFlag   <= (outFlag & ~{bus.clrOut1, bus.clrOut0}) | setOut;
      armed     <= (armed & ~{2{bus.clrArmed}} & ~ackClr) | armSet;
      doneFlag  <= (doneFlag & ~bus.clrDone) | bus.txAck;
      setupFlag <= setupFlag & ~bus.clrSetup;
      if (bus.dirWrite) dirIn <= bus.dirValue;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fwBank  <= '0;
      sieBank <= '0;
    end else if (bus.usbRst) begin
      fwBank  <= '0;
      sieBank <= '0;
    end else begin
      if (cancel) fwBank <= sieBank;
      else if (PP & (bus.setArmed | relFw)) fwBank <= ~fwBank;
      if (PP & bus.rxAccept) sieBank <= ~bus.rxBank;
      else if (PP & bus.txAck) sieBank <= ~sieBank;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) fwPtr <= '0;
    else if (ptrZero) fwPtr <= '0;
    else if ((bus.fwRead | bus.fwWrite) & ~ptrMax) fwPtr <= fwPtr + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt    <= '{default: '0};
      len    <= '{default: '0};
      toggle <= '0;
    end else if (bus.usbRst | bus.fifoRst) begin
      cnt    <= '{default: '0};
      len    <= '{default: '0};
      toggle <= '0;
    end else begin
      if (bus.rxAccept | bus.setup_packet_received) cnt[bus.rxBank] <= bus.rxCount;
      if (bus.rxAccept | bus.setup_packet_received) toggle <= ~bus.rxData1;
      if (bus.setArmed) len[fwBank] <= CNT_W'(fwPtr);
    end
  end

  assign bus.outFlag   = outFlag;
  assign bus.armed     = armed;
  assign bus.setupFlag = setupFlag;
  assign bus.doneFlag  = doneFlag;
  assign bus.dirIn     = dirIn;
  assign bus.fwBank    = fwBank;
  assign bus.sieBank   = sieBank;
  assign bus.toggle    = toggle;
  assign bus.fwPtr     = fwPtr;
  assign bus.byteCnt   = cnt[fwBank];
  assign bus.inLen     = len[sieBank];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  setup_clears_a: assert property (bus.setup_packet_received && !bus.usbRst |=> setupFlag && outFlag == 2'h0
    && armed == 2'h0 && !doneFlag && !dirIn) else $error("setup did not clear status");
  count_hold_a: assert property ((bus.fwRead || bus.fwWrite) && quiet && !relFw && !cancel
    && !bus.setArmed |=> $stable(bus.byteCnt)) else $error("data port access moved byte count");
  ptr_step_a: assert property (bus.fwRead && !ptrMax && !ptrZero |=> fwPtr == $past(fwPtr) + 1'b1)
    else $error("read did not advance pointer");
  fifo_reset_a: assert property (bus.fifoRst && !bus.setArmed && !cancel && !relFw && !bus.usbRst
    |=> fwPtr == '0 && bus.byteCnt == '0 && !toggle && fwBank == $past(fwBank))
    else $error("fifo reset incomplete");
  arm_switch_a: assert property (PP && bus.setArmed && !cancel && !bus.usbRst
    |=> fwBank != $past(fwBank) && armed[$past(fwBank)]) else $error("arm did not switch bank");
  cancel_a: assert property (cancel && !bus.usbRst && !bus.setArmed |=> armed == 2'h0 && fwPtr == '0)
    else $error("cancel kept packet");
  done_set_a: assert property (bus.txAck && !clr ##1 !bus.clrDone && !clr |-> ##1 doneFlag)
    else $error("transmit done lost");
endmodule : uef_ep_state
`default_nettype wire

// ---- logic/uef_endpoint_fifo.sv ----
// Purpose: Endpoint FIFO data port and OUT, IN and SETUP transaction handshakes.
// Assumes: SIE gives decoded tokens, packet bytes and host acknowledge as pulses.
// Notes:   Status outputs show the selected endpoint one cycle late.
`default_nettype none
module uef_endpoint_fifo (
  input  wire logic                                 ref_clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 usbReset,
  input  wire logic                                 sieTokenValid,
  input  wire logic [1:0]                           sieTokenPid,
  input  wire logic [uef_pkg::EP_W-1:0]             sieTokenEp,
  input  wire logic                                 sieRxValid,
  input  wire logic [uef_pkg::BYTE_W-1:0]           sieRxByte,
  input  wire logic                                 sieRxEnd,
  input  wire logic                                 sieRxCrcOk,
  input  wire logic                                 sieRxData1,
  input  wire logic                                 sieTxPull,
  input  wire logic                                 sieHostAck,
  input  wire logic                                 sieTxFail,
  output logic                                      handshakeValid,
  output logic                                      handshakeNak,
  output logic                                      txStart,
  output logic [uef_pkg::CNT_W-1:0]                 txLength,
  output logic [uef_pkg::BYTE_W-1:0]                txByte,
  input  wire logic [uef_pkg::EP_W-1:0]             endpointSelect,
  input  wire logic                                 dataPortRead,
  input  wire logic                                 dataPortWrite,
  input  wire logic [uef_pkg::BYTE_W-1:0]           dataPortWriteData,
  output logic [uef_pkg::BYTE_W-1:0]                dataPortReadData,
  output logic [uef_pkg::CNT_W-1:0]                 endpointByteCount,
  input  wire logic                                 clrOutBank0,
  input  wire logic                                 clrOutBank1,
  input  wire logic                                 setInArmed,
  input  wire logic                                 clrInArmed,
  input  wire logic                                 clrInDone,
  input  wire logic                                 clrSetup,
  input  wire logic                                 dirWrite,
  input  wire logic                                 dirValue,
  input  wire logic [uef_pkg::NUM_EP-1:0]           endpointFifoReset,
  input  wire logic [uef_pkg::NUM_EP-1:0]           epEnable,
  input  wire logic [uef_pkg::NUM_EP-1:0]           epIsIn,
  input  wire logic [uef_pkg::NUM_EP-1:0][1:0]      epType,
  input  wire logic [uef_pkg::NUM_EP-1:0]           intEnable,
  output logic                                      outBank0Received,
  output logic                                      outBank1Received,
  output logic                                      inPacketArmed,
  output logic                                      inTransmitDone,
  output logic                                      setupPacketReceived,
  output logic                                      dirIn,
  output logic                                      dataToggle,
  output logic [uef_pkg::NUM_EP-1:0]                intRequest
);
  import uef_pkg::*;

  // ************************************************************
  // Endpoint state
  // ************************************************************
  uef_ep_if epBus [NUM_EP] ();
  logic [1:0]       outFlagA [NUM_EP];
  logic [1:0]       armedA   [NUM_EP];
  logic             setupA   [NUM_EP];
  logic             doneA    [NUM_EP];
  logic             dirA     [NUM_EP];
  logic             fwBankA  [NUM_EP];
  logic             sieBankA [NUM_EP];
  logic             toggleA  [NUM_EP];
  logic [PTR_W-1:0] fwPtrA   [NUM_EP];
  logic [CNT_W-1:0] cntA     [NUM_EP];
  logic [CNT_W-1:0] inLenA   [NUM_EP];
  logic [NUM_EP-1:0] fwWriteVec;
  logic [BYTE_W-1:0] mem [MEM_BYTES];
  uef_state_e       state;
  logic [EP_W-1:0]  curEp;
  logic             curSetup, curBank;
  logic [PTR_W-1:0] rxPtr, txPtr;
  logic [CNT_W-1:0] rxCnt;
  wire              rxDoneOk = state == ST_RX && sieRxEnd && sieRxCrcOk;

  for (genvar g = 0; g < NUM_EP; g++) begin : gEp
    wire fwHit = endpointSelect == EP_W'(g);
    wire curHit = curEp == EP_W'(g);
    assign epBus[g].fwRead   = dataPortRead & fwHit;
    assign epBus[g].fwWrite  = dataPortWrite & fwHit;
    assign epBus[g].clrOut0  = clrOutBank0 & fwHit;
    assign epBus[g].clrOut1  = clrOutBank1 & fwHit;
    assign epBus[g].setArmed = setInArmed & fwHit;
    assign epBus[g].clrArmed = clrInArmed & fwHit;
    assign epBus[g].clrDone  = clrInDone & fwHit;
    assign epBus[g].clrSetup = clrSetup & fwHit;
    assign epBus[g].dirWrite = dirWrite & fwHit;
    assign epBus[g].dirValue = dirValue;
    assign epBus[g].fifoRst  = endpointFifoReset[g];
    assign epBus[g].usbRst   = usbReset;
    assign epBus[g].rxAccept = rxDoneOk & curHit & ~curSetup;
    assign epBus[g].setup_packet_received  = rxDoneOk & curHit & curSetup;
    assign epBus[g].rxBank   = curBank;
    assign epBus[g].rxData1  = sieRxData1;
    assign epBus[g].rxCount  = rxCnt;
    assign epBus[g].txAck    = state == ST_TX && sieHostAck && curHit;
    assign outFlagA[g] = epBus[g].outFlag;
    assign armedA[g]   = epBus[g].armed;
    assign setupA[g]   = epBus[g].setupFlag;
    assign doneA[g]    = epBus[g].doneFlag;
    assign dirA[g]     = epBus[g].dirIn;
    assign fwBankA[g]  = epBus[g].fwBank;
    assign sieBankA[g] = epBus[g].sieBank;
    assign toggleA[g]  = epBus[g].toggle;
    assign fwPtrA[g]   = epBus[g].fwPtr;
    assign cntA[g]     = epBus[g].byteCnt;
    assign inLenA[g]   = epBus[g].inLen;
    assign fwWriteVec[g] = epBus[g].fwWrite;
    uef_ep_state #(
      .CAP (EP_CAP[g]),
      .PP  (EP_BANKS[g] == BANKS_PP)
    ) uState (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .bus     (epBus[g].ep)
    );
  end

  // ************************************************************
  // Token decode
  // ************************************************************
  wire       isCtl    = epType[sieTokenEp] == TYPE_CONTROL;
  wire       tokPp    = EP_BANKS[sieTokenEp] == BANKS_PP;
  wire       tokOk    = sieTokenValid && state == ST_IDLE && epEnable[sieTokenEp];
  wire       tokOut   = tokOk && sieTokenPid == PID_OUT && (isCtl || !epIsIn[sieTokenEp]);
  wire       tokIn    = tokOk && sieTokenPid == PID_IN && (isCtl || epIsIn[sieTokenEp]);
  wire       tokSetup = tokOk && sieTokenPid == PID_SETUP && isCtl;
  wire [1:0] tokFlag  = outFlagA[sieTokenEp];
  wire       tokSb    = sieBankA[sieTokenEp];
  wire       outBank  = tokPp & (tokFlag[tokSb] ? ~tokSb : tokSb);
  // Control OUT held off while setup unread or an IN data stage is set up
  wire       outBusy  = tokPp ? &tokFlag
                              : (tokFlag[0] | setupA[sieTokenEp] | (isCtl & dirA[sieTokenEp]));
  wire       inReady  = armedA[sieTokenEp][tokSb];

  // ************************************************************
  // FIFO memory addressing
  // ************************************************************
  wire [EP_W-1:0]   sel    = endpointSelect;
  wire [ADDR_W-1:0] fwAddr = ADDR_W'(EP_BASE[sel] + fwBankA[sel] * EP_CAP[sel] + fwPtrA[sel]);
  wire [ADDR_W-1:0] rxAddr = ADDR_W'(EP_BASE[curEp] + curBank * EP_CAP[curEp] + rxPtr);
  wire [ADDR_W-1:0] txAddr = ADDR_W'(EP_BASE[curEp] + sieBankA[curEp] * EP_CAP[curEp] + txPtr);
  wire              rxRoom = rxPtr < PTR_W'(EP_CAP[curEp]);
  wire              rxWe   = state == ST_RX && sieRxValid && rxRoom;
  wire              fwWe   = dataPortWrite && fwPtrA[sel] < PTR_W'(EP_CAP[sel]);

  // No reset on the array: contents are only meaningful behind a count
  always_ff @(posedge ref_clk) begin
    if (rxWe) mem[rxAddr] <= sieRxByte;
    if (fwWe) mem[fwAddr] <= dataPortWriteData;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) dataPortReadData <= '0;
    else if (dataPortRead) dataPortReadData <= mem[fwAddr];
  end

  // ************************************************************
  // Transaction sequencer
  // ************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_IDLE;
      curEp    <= '0;
      curSetup <= '0;
      curBank  <= '0;
      rxPtr    <= '0;
      rxCnt    <= '0;
      txPtr    <= '0;
    end else if (usbReset) begin
      state    <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          curEp    <= sieTokenEp;
          curSetup <= tokSetup;
          curBank  <= tokSetup ? 1'b0 : outBank;
          rxPtr    <= '0;
          rxCnt    <= '0;
          txPtr    <= '0;
          if (tokSetup || (tokOut && !outBusy)) state <= ST_RX;
          else if (tokOut) state <= ST_DROP;
          else if (tokIn && inReady) state <= ST_TX;
        end
        ST_RX: begin
          if (sieRxValid) rxCnt <= rxCnt + 1'b1;
          if (rxWe) rxPtr <= rxPtr + 1'b1;
          if (sieRxEnd) state <= ST_IDLE;
        end
        ST_DROP: begin
          if (sieRxEnd) state <= ST_IDLE;
        end
        ST_TX: begin
          if (sieTxPull) txPtr <= txPtr + 1'b1;
          // A failed attempt keeps the bank armed, so the next IN retries
          if (sieHostAck || sieTxFail) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  wire nakNow = (tokIn && !inReady) || (state == ST_DROP && sieRxEnd && sieRxCrcOk);
  wire ackNow = rxDoneOk;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      handshakeValid <= '0;
      handshakeNak   <= '0;
      txStart        <= '0;
      txLength       <= '0;
      txByte         <= '0;
    end else begin
      handshakeValid <= (nakNow || ackNow) && !usbReset;
      handshakeNak   <= nakNow;
      txStart        <= tokIn && inReady && !usbReset;
      if (tokIn && inReady) txLength <= inLenA[sieTokenEp];
      if (state == ST_TX && sieTxPull) txByte <= mem[txAddr];
    end
  end

  // ************************************************************
  // Firmware status view
  // ************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      outBank0Received    <= '0;
      outBank1Received    <= '0;
      inPacketArmed       <= '0;
      inTransmitDone      <= '0;
      setupPacketReceived <= '0;
      dirIn               <= '0;
      dataToggle          <= '0;
      endpointByteCount   <= '0;
    end else begin
      outBank0Received    <= outFlagA[sel][0];
      outBank1Received    <= outFlagA[sel][1];
      inPacketArmed       <= |armedA[sel];
      inTransmitDone      <= doneA[sel];
      setupPacketReceived <= setupA[sel];
      dirIn               <= dirA[sel];
      dataToggle          <= toggleA[sel];
      endpointByteCount   <= cntA[sel];
    end
  end

  wire [NUM_EP-1:0] irqSrc;
  for (genvar e = 0; e < NUM_EP; e++) begin : gIrq
    assign irqSrc[e] = |outFlagA[e] | setupA[e] | doneA[e];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) intRequest <= '0;
    else intRequest <= intEnable & irqSrc;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  port_select_a: assert property (dataPortWrite |-> fwWriteVec == NUM_EP'(1) << sel)
    else $error("write reached another endpoint");
  out_nak_a: assert property (state == ST_DROP && sieRxEnd && sieRxCrcOk && !usbReset
    |=> handshakeValid && handshakeNak) else $error("held bank not NAKed");
  out_take_a: assert property (tokOut && !outBusy && !usbReset |=> state == ST_RX)
    else $error("free bank refused");
  in_nak_a: assert property (tokIn && !inReady && !usbReset |=> handshakeValid && handshakeNak && !txStart)
    else $error("unarmed IN not NAKed");
  overflow_a: assert property (state == ST_RX && sieRxValid && !rxRoom && !usbReset
    |=> rxPtr == $past(rxPtr) && rxCnt == $past(rxCnt) + 1'b1) else $error("overflow handling wrong");
  zlp_flag_a: assert property (rxDoneOk && rxCnt == '0 && !curSetup && !usbReset
    |=> outFlagA[curEp][$past(curBank)] && cntA[curEp] == '0) else $error("zero-length packet lost");
  pp_out_c: cover property (tokOut && tokPp && tokFlag == 2'h1 ##1 state == ST_RX);
  in_ack_c: cover property (state == ST_TX && sieHostAck);
  setup_c: cover property (rxDoneOk && curSetup);
endmodule : uef_endpoint_fifo
`default_nettype wire

// ---- sim/uef_host_model.sv ----
// Purpose: Host seen through the SIE: tokens, OUT bytes, IN pulls, acks.
// Assumes: One transaction at a time; drives 1 ns after the edge.
// Notes:   Result 0 ACK, 1 NAK, 2 silent, 3 IN data sent.
`default_nettype none
module uef_host_model (
  input  wire logic       ref_clk,
  input  wire logic       handshakeValid,
  input  wire logic       handshakeNak,
  input  wire logic       txStart,
  input  wire logic [7:0] txLength,
  input  wire logic [7:0] txByte,
  output logic            sieTokenValid,
  output logic [1:0]      sieTokenPid,
  output logic [1:0]      sieTokenEp,
  output logic            sieRxValid,
  output logic [7:0]      sieRxByte,
  output logic            sieRxEnd,
  output logic            sieRxCrcOk,
  output logic            sieRxData1,
  output logic            sieTxPull,
  output logic            sieHostAck,
  output logic            sieTxFail
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sum of IN bytes seen in the last fetch; failNext makes the next IN end without ack
  logic [7:0] txSum;
  logic       failNext = 1'b0;
  initial {sieTokenValid, sieTokenPid, sieTokenEp, sieRxValid, sieRxByte, sieRxEnd} = '0;
  initial {sieRxCrcOk, sieRxData1, sieTxPull, sieHostAck, sieTxFail} = '0;
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic token(input logic [1:0] pid, input logic [1:0] ep);
    sieTokenPid   = pid;
    sieTokenEp    = ep;
    sieTokenValid = 1'b1;
    tick();
    sieTokenValid = 1'b0;
  endtask : token
  task automatic send(input logic [1:0] pid, ep, input int n, input logic [7:0] seed, output logic [1:0] res);
    res = 2'h2;
    token(pid, ep);
    for (int i = 0; i < n; i++) begin
      sieRxValid = 1'b1;
      sieRxByte  = seed + i[7:0];
      tick();
    end
    sieRxValid = 1'b0;
    sieRxByte  = ~sieRxByte;
    sieRxEnd   = 1'b1;
    sieRxCrcOk = 1'b1;
    tick();
    sieRxEnd   = 1'b0;
    for (int i = 0; i < 4 && res == 2'h2; i++) begin
      if (handshakeValid === 1'b1) res = {1'b0, handshakeNak};
      else tick();
    end
  endtask : send
  task automatic fetch(input logic [1:0] ep, output logic [1:0] res, output logic [7:0] len);
    res = 2'h2;
    len = 8'hff;
    txSum = 8'h0;
    token(2'h1, ep);
    for (int i = 0; i < 4 && res == 2'h2; i++) begin
      if (handshakeValid === 1'b1) res = {1'b0, handshakeNak};
      else if (txStart === 1'b1) res = 2'h3;
      else tick();
    end
    if (res == 2'h3) begin
      len = txLength;
      for (int i = 0; i < len; i++) begin
        sieTxPull = 1'b1;
        tick();
        sieTxPull = 1'b0;
        txSum     = txSum + txByte;
        tick();
      end
      sieHostAck = ~failNext;
      sieTxFail  = failNext;
      tick();
      {sieHostAck, sieTxFail, failNext} = '0;
    end
  endtask : fetch
endmodule : uef_host_model
`default_nettype wire

// ---- sim/usb_endpoint_fifo_transactions_tb.sv ----
// Purpose: Firmware-side sequences against the endpoint FIFO block.
// Assumes: ep0 control, ep1 ping-pong IN, ep2 ping-pong OUT.
// Notes:   Status is looked at two edges after the firmware strobe.
`default_nettype none
module usb_endpoint_fifo_transactions_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uef_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, usbReset = 1'b0, dataPortRead = 1'b0, dataPortWrite = 1'b0;
  logic clrOutBank0 = 1'b0, clrOutBank1 = 1'b0, setInArmed = 1'b0, clrInArmed = 1'b0, clrInDone = 1'b0;
  logic clrSetup = 1'b0, dirWrite = 1'b0, dirValue = 1'b0, sieTokenValid, sieRxValid, sieRxEnd, sieRxCrcOk;
  logic sieRxData1, sieTxPull, sieHostAck, sieTxFail, handshakeValid, handshakeNak, txStart, dirIn, dataToggle;
  logic outBank0Received, outBank1Received, inPacketArmed, inTransmitDone, setupPacketReceived;
  logic [1:0] sieTokenPid, sieTokenEp, res, endpointSelect = 2'h0;
  logic [7:0] sieRxByte, txLength, txByte, dataPortReadData, endpointByteCount, len, dataPortWriteData = 8'h0;
  logic [2:0] intRequest, endpointFifoReset = 3'h0, epEnable = 3'h7, epIsIn = 3'h2, intEnable = 3'h7;
  logic [2:0][1:0] epType = {2'h2, 2'h2, 2'h0};
  int bad_count = 0, samples_checked = 0;
  uef_endpoint_fifo uut (.*);
  uef_host_model host (.*);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick(2);
  endtask : pulse
  task automatic rd_n(input int n, input logic [7:0] seed);
    dataPortRead = 1'b1;
    for (int i = 0; i < n; i++) begin
      tick();
      chk(dataPortReadData, seed + i[7:0]);
    end
    dataPortRead = 1'b0;
  endtask : rd_n
  task automatic wr_n(input int n, input logic [7:0] seed);
    dataPortWrite = 1'b1;
    for (int i = 0; i < n; i++) begin
      dataPortWriteData = seed + i[7:0];
      tick();
    end
    dataPortWrite = 1'b0;
  endtask : wr_n
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge ref_clk);
    chk({intRequest, outBank0Received, setupPacketReceived, inPacketArmed, txStart}, 8'h0);
    #1 reset_n = 1'b1;
    tick(2);
    host.send(PID_OUT, 2'h0, 34, 8'h10, res);
    chk(res, 8'h0);
    tick(2);
    chk({intRequest, outBank0Received}, 8'h3);
    chk({dataToggle, endpointByteCount}, 9'h122);
    rd_n(EP_CAP[0], 8'h10);
    chk(endpointByteCount, 8'd34);
    host.send(PID_OUT, 2'h0, 2, 8'h0, res);
    chk(res, 8'h1);
    pulse(clrOutBank0);
    endpointFifoReset = 3'h1;
    tick();
    endpointFifoReset = 3'h0;
    tick(2);
    chk({dataToggle, endpointByteCount}, 9'h0);
    host.send(PID_OUT, 2'h0, 0, 8'h0, res);
    tick(2);
    chk({res, outBank0Received, endpointByteCount}, 9'h100);
    host.send(PID_SETUP, 2'h0, 8, 8'h40, res);
    tick(2);
    chk({res, outBank0Received, setupPacketReceived}, 8'h1);
    rd_n(8, 8'h40);
    pulse(clrSetup);
    dirValue = 1'b1;
    pulse(dirWrite);
    chk(dirIn, 8'h1);
    dirValue = 1'b0;
    pulse(dirWrite);
    endpointSelect = 2'h2;
    for (int i = 0; i < 3; i++) begin
      host.send(PID_OUT, 2'h2, 4 - i, 8'h20 + 8'(i * 16), res);
      chk(res, (i == 2) ? 8'h1 : 8'h0);
    end
    tick(2);
    chk({outBank0Received, outBank1Received, endpointByteCount}, 10'h304);
    rd_n(4, 8'h20);
    pulse(clrOutBank0);
    chk({outBank0Received, outBank1Received, endpointByteCount}, 10'h103);
    endpointSelect = 2'h1;
    host.fetch(2'h1, res, len);
    chk(res, 8'h1);
    wr_n(5, 8'h50);
    pulse(setInArmed);
    chk({inPacketArmed, endpointByteCount}, 9'h100);
    host.failNext = 1'b1;
    host.fetch(2'h1, res, len);
    chk({res, len, inTransmitDone}, 11'h60a);
    host.fetch(2'h1, res, len);
    chk({res, len}, 10'h305);
    chk(host.txSum, 8'h9a);
    tick(2);
    chk({intRequest, inTransmitDone}, 8'hd);
    pulse(clrInDone);
    pulse(setInArmed);
    host.fetch(2'h1, res, len);
    chk({res, len}, 10'h300);
    wr_n(2, 8'h60);
    pulse(setInArmed);
    pulse(clrInArmed);
    host.fetch(2'h1, res, len);
    chk({inPacketArmed, res}, 8'h1);
    pulse(usbReset);
    chk({intRequest, inTransmitDone}, 8'h0);
    wrap_up();
  end
endmodule : usb_endpoint_fifo_transactions_tb
`default_nettype wire
